// ### design/dmm_pkg.sv
// Purpose: Constants and types of the DAC device memory map block.
// Assumes: 16-bit words, 5-bit word addresses, 12-bit output codes.
// Notes: Shared by the register bank and the verification side.
// Functional notes
// - Volatile words sit at 00h, 01h, 08h, 09h, 0Ah and 0Bh; 02h-07h and 0Ch-0Fh are reserved.
// - Nonvolatile words sit at 10h, 11h, 18h, 19h and 1Ah (gain plus 7-bit target address); the rest are reserved.
// - Volatile words take their defaults during reset, then their nonvolatile copies before any access is served.
// - On power-on release each nonvolatile word is copied into its volatile twin; from 1Ah only the gain field reaches 0Ah.
// - Programming of a nonvolatile word starts at the acknowledge of the write command.
// - A nonvolatile write leaves the volatile twin unchanged.
// - Volatile codes pair with config locks, nonvolatile codes with code locks, 1Ah with the address lock, all changed only by high-voltage commands.
// - Five nonvolatile lock bits live outside the map: two per channel and one address lock.
// - The lock status word shows the per-channel lock bits.
// - Unimplemented bits of an implemented word read as zero.
// - A normal read or write to a reserved address is a command error and is not acknowledged.
// - A read of a reserved location returns all ones.
// - A high-voltage command aimed at an unimplemented lock bit is a command error and is not acknowledged.
// - Every location is one 16-bit word.
// - After a command error the command engine idles until the next bus start condition.
package dmm_pkg;
    localparam int DW = 16;
    localparam int AW = 5;
    localparam int NV_DEPTH = 16;
    localparam int LOCK_W = 5;
    localparam logic [AW-1:0] A_CH0 = 5'h00;
    localparam logic [AW-1:0] A_CH1 = 5'h01;
    localparam logic [AW-1:0] A_VREF = 5'h08;
    localparam logic [AW-1:0] A_PD = 5'h09;
    localparam logic [AW-1:0] A_GS = 5'h0A;
    localparam logic [AW-1:0] A_LOCK = 5'h0B;
    localparam logic [AW-1:0] A_NV_CH0 = 5'h10;
    localparam logic [AW-1:0] A_NV_CH1 = 5'h11;
    localparam logic [AW-1:0] A_NV_VREF = 5'h18;
    localparam logic [AW-1:0] A_NV_PD = 5'h19;
    localparam logic [AW-1:0] A_NV_GS = 5'h1A;
    localparam int NV_IDX_CH0 = 0;
    localparam int NV_IDX_CH1 = 1;
    localparam int NV_IDX_VREF = 8;
    localparam int NV_IDX_PD = 9;
    localparam int NV_IDX_GS = 10;
    localparam logic [NV_DEPTH-1:0] NV_IMPL = 16'h0703;
    localparam logic [DW-1:0] CODE_MASK = 16'h0FFF;
    localparam logic [DW-1:0] CFG_MASK = 16'h000F;
    localparam logic [DW-1:0] NV_GS_MASK = 16'h03FF;
    localparam logic [DW-1:0] ADDR_FIELD_MASK = 16'h007F;
    localparam int GAIN_LSB = 8;
    localparam int GAIN_W = 2;
    localparam int POR_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int TADDR_W = 7;
    localparam int CFG_W = 4;
    localparam logic [DW-1:0] DEF_CODE = 16'h07FF;
    localparam logic [DW-1:0] DEF_CFG = 16'h0000;
    localparam logic [DW-1:0] DEF_NV_GS = 16'h00E0;
    localparam logic [DW-1:0] RSV_READ = 16'hFFFF;
    localparam logic [DW-1:0] ZERO_WORD = 16'h0000;
    localparam int LK_CH0_CFG = 0;
    localparam int LK_CH0_CODE = 1;
    localparam int LK_CH1_CFG = 2;
    localparam int LK_CH1_CODE = 3;
    localparam int LK_ADDR = 4;
    localparam logic [LOCK_W-1:0] LOCK_FACTORY = 5'h10;
    localparam int CLK_PERIOD_NS = 20;
    localparam int NV_PROG_TIME_NS = 5000000;
    localparam int NV_PROG_CYCLES_DEF = (NV_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 20;
    typedef enum logic [1:0] {
        CMD_READ = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_HV_EN = 2'h2,
        CMD_HV_DIS = 2'h3
    } dmm_cmd_t;
    typedef enum logic [1:0] {
        ST_COPY = 2'h0,
        ST_READY = 2'h1,
        ST_ERROR = 2'h3
    } dmm_state_t;
endpackage

// ### design/dmm_core.sv
// Purpose: Volatile and nonvolatile word map of a two-channel DAC behind a serial command front end.
// Assumes: The serial front end delivers decoded commands and start-condition pulses on core_clk.
// Notes: The nonvolatile store and lock bits survive reset_n; nv_factory_init writes factory values.
`timescale 1ns/10ps
module dmm_core
    import dmm_pkg::*;
#(
    parameter int NV_PROG_CYCLES = NV_PROG_CYCLES_DEF
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic nv_factory_init,
    input wire logic high_voltage_cmd_pin,
    input wire logic bus_start,
    input wire logic cmd_valid,
    input wire dmm_cmd_t cmd_kind,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [DW-1:0] cmd_wdata,
    output logic cmd_ack,
    output logic cmd_nack,
    output logic [DW-1:0] cmd_rdata,
    output logic ready,
    output logic nv_prog_busy,
    output logic [DW-1:0] chan0_code,
    output logic [DW-1:0] chan1_code,
    output logic [CFG_W-1:0] vref_sel,
    output logic [CFG_W-1:0] pd_cfg,
    output logic [GAIN_W-1:0] gain_sel,
    output logic [TADDR_W-1:0] target_addr,
    output logic [LOCK_W-1:0] lock_bits
);
    dmm_state_t state_ff;
    dmm_state_t nxt_state;
    logic hv_meta_ff;
    logic hv_sync_ff;
    logic ack_ff;
    logic nack_ff;
    logic [DW-1:0] rdata_ff;
    logic [DW-1:0] ch0_ff;
    logic [DW-1:0] ch1_ff;
    logic [CFG_W-1:0] vref_ff;
    logic [CFG_W-1:0] pd_ff;
    logic [GAIN_W-1:0] gain_ff;
    logic por_ff;
    logic [LOCK_W-1:0] lock_ff;
    logic [LOCK_W-1:0] nxt_lock;
    logic prog_busy_ff;
    logic [PROG_CNT_W-1:0] prog_cnt_ff;
    logic [3:0] prog_idx_ff;
    logic [DW-1:0] prog_data_ff;
    logic [DW-1:0] nv_word [NV_DEPTH];
    logic [DW-1:0] rd_val;
    logic [DW-1:0] nv_wr_val;

    function automatic logic [DW-1:0] nv_default(input int idx);
        if (idx == NV_IDX_CH0 || idx == NV_IDX_CH1)
            return DEF_CODE;
        else if (idx == NV_IDX_GS)
            return DEF_NV_GS;
        else
            return DEF_CFG;
    endfunction

    function automatic logic [DW-1:0] nv_mask(input logic [3:0] idx);
        if (idx == NV_IDX_CH0[3:0] || idx == NV_IDX_CH1[3:0])
            return CODE_MASK;
        else if (idx == NV_IDX_GS[3:0])
            return NV_GS_MASK;
        else
            return CFG_MASK;
    endfunction

    // Address classes
    wire a_ch0 = cmd_addr == A_CH0;
    wire a_ch1 = cmd_addr == A_CH1;
    wire a_vref = cmd_addr == A_VREF;
    wire a_pd = cmd_addr == A_PD;
    wire a_gs = cmd_addr == A_GS;
    wire a_lock = cmd_addr == A_LOCK;
    wire a_nv_ch0 = cmd_addr == A_NV_CH0;
    wire a_nv_ch1 = cmd_addr == A_NV_CH1;
    wire a_nv_gs = cmd_addr == A_NV_GS;
    wire a_nv_cfg = (cmd_addr == A_NV_VREF) || (cmd_addr == A_NV_PD);
    wire a_vol = a_ch0 || a_ch1 || a_vref || a_pd || a_gs || a_lock;
    wire a_nvm = a_nv_ch0 || a_nv_ch1 || a_nv_gs || a_nv_cfg;
    wire a_impl = a_vol || a_nvm;
    wire [3:0] nv_idx = cmd_addr[3:0];

    // Command qualification
    wire st_ready = state_ff == ST_READY;
    wire st_error = state_ff == ST_ERROR;
    wire cmd_take = cmd_valid && (st_ready || (st_error && bus_start));
    wire is_hv = (cmd_kind == CMD_HV_EN) || (cmd_kind == CMD_HV_DIS);
    wire is_wr = cmd_kind == CMD_WRITE;
    wire is_rd = cmd_kind == CMD_READ;
    wire hv_target = a_ch0 || a_ch1 || a_nv_ch0 || a_nv_ch1 || a_nv_gs;
    wire hv_ok = hv_sync_ff && hv_target;
    // A second nonvolatile write while one is programming would be lost, so it is refused
    wire nv_clash = is_wr && a_nvm && prog_busy_ff;
    wire norm_ok = a_impl && !nv_clash;
    wire cmd_good = is_hv ? hv_ok : norm_ok;
    wire take_good = cmd_take && cmd_good;
    wire take_bad = cmd_valid && !cmd_good && (st_ready || (st_error && bus_start));
    wire refuse = cmd_valid && !cmd_take;
    wire vol_wr = take_good && is_wr && a_vol;
    wire nv_wr = take_good && is_wr && a_nvm;
    wire hv_wr = take_good && is_hv;
    wire hv_set = cmd_kind == CMD_HV_EN;
    wire prog_done = prog_busy_ff && (prog_cnt_ff == '0);
    wire [DW-1:0] wmasked = cmd_wdata & nv_mask(nv_idx);

    // Address write protect keeps the stored target address under the lock
    assign nv_wr_val = (a_nv_gs && lock_ff[LK_ADDR])
        ? ((wmasked & ~ADDR_FIELD_MASK) | (nv_word[NV_IDX_GS] & ADDR_FIELD_MASK))
        : wmasked;

    // Read selection; unused bits of implemented words are zero
    always_comb
    begin
        rd_val = RSV_READ;
        if (a_ch0)
            rd_val = ch0_ff & CODE_MASK;
        else if (a_ch1)
            rd_val = ch1_ff & CODE_MASK;
        else if (a_vref)
            rd_val = {{(DW-CFG_W){1'b0}}, vref_ff};
        else if (a_pd)
            rd_val = {{(DW-CFG_W){1'b0}}, pd_ff};
        else if (a_gs)
        begin
            rd_val = ZERO_WORD;
            rd_val[GAIN_LSB +: GAIN_W] = gain_ff;
            rd_val[POR_BIT] = por_ff;
            rd_val[BUSY_BIT] = prog_busy_ff;
        end
        else if (a_lock)
            rd_val = {{(DW-CFG_W){1'b0}}, lock_ff[LK_CH1_CODE:LK_CH0_CFG]};
        else if (a_nvm)
            rd_val = nv_word[nv_idx] & nv_mask(nv_idx);
    end

    // Lock bit update by high-voltage commands only
    always_comb
    begin
        nxt_lock = lock_ff;
        if (hv_wr)
        begin
            if (a_ch0)
                nxt_lock[LK_CH0_CFG] = hv_set;
            else if (a_ch1)
                nxt_lock[LK_CH1_CFG] = hv_set;
            else if (a_nv_ch0)
                nxt_lock[LK_CH0_CODE] = hv_set;
            else if (a_nv_ch1)
                nxt_lock[LK_CH1_CODE] = hv_set;
            else if (a_nv_gs)
                nxt_lock[LK_ADDR] = hv_set;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_COPY: nxt_state = ST_READY;
            ST_READY: nxt_state = take_bad ? ST_ERROR : ST_READY;
            ST_ERROR:
            begin
                if (bus_start)
                    nxt_state = take_bad ? ST_ERROR : ST_READY;
            end
            default: nxt_state = ST_COPY;
        endcase
    end

    // High-voltage detect comes from a pin comparator
    always_ff @(posedge core_clk)
    begin
        hv_meta_ff <= high_voltage_cmd_pin;
        hv_sync_ff <= hv_meta_ff;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            state_ff <= ST_COPY;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ack_ff <= 1'b0;
            nack_ff <= 1'b0;
            rdata_ff <= ZERO_WORD;
        end
        else
        begin
            ack_ff <= take_good;
            nack_ff <= take_bad || refuse;
            if (cmd_take && is_rd)
                rdata_ff <= rd_val;
        end
    end

    // Defaults during reset, then one copy cycle from the nonvolatile store
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ch0_ff <= DEF_CODE;
            ch1_ff <= DEF_CODE;
            vref_ff <= DEF_CFG[CFG_W-1:0];
            pd_ff <= DEF_CFG[CFG_W-1:0];
            gain_ff <= DEF_CFG[GAIN_LSB +: GAIN_W];
            por_ff <= 1'b1;
        end
        else if (state_ff == ST_COPY)
        begin
            ch0_ff <= nv_word[NV_IDX_CH0] & CODE_MASK;
            ch1_ff <= nv_word[NV_IDX_CH1] & CODE_MASK;
            vref_ff <= nv_word[NV_IDX_VREF][CFG_W-1:0];
            pd_ff <= nv_word[NV_IDX_PD][CFG_W-1:0];
            gain_ff <= nv_word[NV_IDX_GS][GAIN_LSB +: GAIN_W];
        end
        else if (vol_wr)
        begin
            if (a_ch0)
                ch0_ff <= cmd_wdata & CODE_MASK;
            if (a_ch1)
                ch1_ff <= cmd_wdata & CODE_MASK;
            if (a_vref)
                vref_ff <= cmd_wdata[CFG_W-1:0];
            if (a_pd)
                pd_ff <= cmd_wdata[CFG_W-1:0];
            if (a_gs)
            begin
                gain_ff <= cmd_wdata[GAIN_LSB +: GAIN_W];
                if (!cmd_wdata[POR_BIT])
                    por_ff <= 1'b0;
            end
        end
    end

    // Programming starts at the edge that raises the acknowledge
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            prog_busy_ff <= 1'b0;
            prog_cnt_ff <= '0;
            prog_idx_ff <= '0;
            prog_data_ff <= ZERO_WORD;
        end
        else if (nv_wr)
        begin
            prog_busy_ff <= 1'b1;
            prog_cnt_ff <= PROG_CNT_W'(NV_PROG_CYCLES - 1);
            prog_idx_ff <= nv_idx;
            prog_data_ff <= nv_wr_val;
        end
        else if (prog_busy_ff)
        begin
            if (prog_done)
                prog_busy_ff <= 1'b0;
            else
                prog_cnt_ff <= prog_cnt_ff - 1'b1;
        end
    end

    // Lock bits are nonvolatile: reset_n does not touch them
    always_ff @(posedge core_clk)
    begin
        if (nv_factory_init)
            lock_ff <= LOCK_FACTORY;
        else
            lock_ff <= nxt_lock;
    end

    // Nonvolatile store, one entry per word; holes are tied to zero
    genvar gi;
    generate
        for (gi = 0; gi < NV_DEPTH; gi++)
        begin : g_nv
            if (NV_IMPL[gi])
            begin : g_impl
                always_ff @(posedge core_clk)
                begin
                    if (nv_factory_init)
                        nv_word[gi] <= nv_default(gi);
                    else if (prog_done && prog_idx_ff == 4'(gi))
                        nv_word[gi] <= prog_data_ff;
                end
            end
            else
            begin : g_hole
                assign nv_word[gi] = ZERO_WORD;
            end
        end
    endgenerate

    assign cmd_ack = ack_ff;
    assign cmd_nack = nack_ff;
    assign cmd_rdata = rdata_ff;
    assign ready = st_ready;
    assign nv_prog_busy = prog_busy_ff;
    assign chan0_code = ch0_ff;
    assign chan1_code = ch1_ff;
    assign vref_sel = vref_ff;
    assign pd_cfg = pd_ff;
    assign gain_sel = gain_ff;
    assign target_addr = nv_word[NV_IDX_GS][TADDR_W-1:0];
    assign lock_bits = lock_ff;
endmodule

// ### dv/dmm_core_props.sv
// Purpose: Concurrent checks on the dmm_core command port.
// Assumes: Only the top ports are visible; one clock domain.
// Notes: Bound into every dmm_core instance.
`timescale 1ns/10ps
module dmm_core_props
    import dmm_pkg::*;
#(
    parameter int NV_PROG_CYCLES = 8
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic bus_start,
    input wire logic cmd_valid,
    input wire dmm_cmd_t cmd_kind,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [DW-1:0] cmd_wdata,
    input wire logic cmd_ack,
    input wire logic cmd_nack,
    input wire logic [DW-1:0] cmd_rdata,
    input wire logic ready,
    input wire logic nv_prog_busy,
    input wire logic [DW-1:0] chan0_code,
    input wire logic [LOCK_W-1:0] lock_bits
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire nv_hit = NV_IMPL[cmd_addr[3:0]];
    // 0Bh has no nonvolatile twin, so the low nibble alone cannot decide
    wire rsv = cmd_addr[4] ? !nv_hit : !(nv_hit || cmd_addr[3:0] == 4'hB);
    wire hv_ok = cmd_addr[3:1] == 3'h0 || cmd_addr == A_NV_GS;
    wire take = cmd_valid && ready;
    logic [PROG_CNT_W-1:0] busy_cnt_ff;
    wire [PROG_CNT_W-1:0] nxt_busy_cnt = nv_prog_busy ? busy_cnt_ff + 20'h00001 : '0;
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            busy_cnt_ff <= '0;
        else
            busy_cnt_ff <= nxt_busy_cnt;
    end
    property p_rsv_nack;
        take && !cmd_kind[1] && rsv |=> cmd_nack && !cmd_ack && !ready;
    endproperty
    a_rsv_nack: assert property (p_rsv_nack) else $error("reserved access not refused");
    property p_rsv_ones;
        take && cmd_kind == CMD_READ && rsv |=> cmd_rdata == RSV_READ;
    endproperty
    a_rsv_ones: assert property (p_rsv_ones) else $error("reserved read not all ones");
    property p_recover;
        !ready && $past(reset_n) && bus_start && cmd_valid && cmd_kind == CMD_READ && !rsv |=> cmd_ack;
    endproperty
    a_recover: assert property (p_recover) else $error("start did not clear error");
    property p_nv_start;
        take && cmd_kind == CMD_WRITE && cmd_addr[4] && nv_hit && !nv_prog_busy |=> cmd_ack && nv_prog_busy;
    endproperty
    a_nv_start: assert property (p_nv_start) else $error("programming not started at ack");
    property p_busy_len;
        $fell(nv_prog_busy) && $past(reset_n) |-> busy_cnt_ff == NV_PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("programming time wrong");
    property p_nv_keep;
        take && cmd_kind == CMD_WRITE && cmd_addr[4] |=> $stable(chan0_code);
    endproperty
    a_nv_keep: assert property (p_nv_keep) else $error("active code moved on stored write");
    property p_vol_write;
        take && cmd_kind == CMD_WRITE && cmd_addr == A_CH0 |=> chan0_code == ($past(cmd_wdata) & CODE_MASK);
    endproperty
    a_vol_write: assert property (p_vol_write) else $error("active code write wrong");
    property p_lock_read;
        take && cmd_kind == CMD_READ && cmd_addr == A_LOCK |=> cmd_rdata == {12'h000, lock_bits[3:0]};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock status read wrong");
    property p_hv_bad;
        cmd_valid && cmd_kind[1] && !hv_ok |=> cmd_nack && !cmd_ack;
    endproperty
    a_hv_bad: assert property (p_hv_bad) else $error("bad lock command accepted");
    property p_por_load;
        reset_n && !$past(reset_n) |-> !ready ##1 ready;
    endproperty
    a_por_load: assert property (p_por_load) else $error("load cycle after reset wrong");
endmodule
bind dmm_core dmm_core_props #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) dmm_core_props_inst (.core_clk(core_clk),
    .reset_n(reset_n), .bus_start(bus_start), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata), .ready(ready),
    .nv_prog_busy(nv_prog_busy), .chan0_code(chan0_code), .lock_bits(lock_bits));

// ### dv/dmm_cmd_master.sv
// Purpose: Bus controller model issuing decoded commands.
// Assumes: The answer is sampled one edge after the valid edge.
// Notes: Idle address and data are inverted so stale values are never trusted.
`timescale 1ns/10ps
module dmm_cmd_master
    import dmm_pkg::*;
(
    input wire logic core_clk,
    input wire logic cmd_ack,
    input wire logic cmd_nack,
    input wire logic [DW-1:0] cmd_rdata,
    output logic bus_start,
    output logic cmd_valid,
    output dmm_cmd_t cmd_kind,
    output logic [AW-1:0] cmd_addr,
    output logic [DW-1:0] cmd_wdata
);
    initial
    begin
        bus_start = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = CMD_READ;
        cmd_addr = 5'h00;
        cmd_wdata = 16'h0000;
    end
    // Start rides with the command: the only way out of an error
    task automatic issue(input dmm_cmd_t k, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic st,
        input int gap, output logic ak, output logic nk, output logic [DW-1:0] rd);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        bus_start = st;
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge core_clk);
        #1;
        ak = cmd_ack;
        nk = cmd_nack;
        rd = cmd_rdata;
        bus_start = 1'b0;
        cmd_valid = 1'b0;
        cmd_addr = ~a;
        cmd_wdata = ~d;
    endtask
endmodule

// ### dv/dac_device_memory_map_tb.sv
// Purpose: Self-checking bench for the memory map block.
// Assumes: Short programming time set through NV_PROG_CYCLES.
// Notes: Scenarios share one command task of the controller model.
`timescale 1ns/10ps
module dac_device_memory_map_tb
    import dmm_pkg::*;
;
    localparam int NPC = 8;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic nv_factory_init = 1'b1;
    logic high_voltage_cmd_pin = 1'b0;
    logic bus_start, cmd_valid, cmd_ack, cmd_nack, ready, nv_prog_busy, ak, nk;
    dmm_cmd_t cmd_kind;
    logic [AW-1:0] cmd_addr;
    logic [DW-1:0] cmd_wdata, cmd_rdata, chan0_code, chan1_code, rd;
    logic [CFG_W-1:0] vref_sel, pd_cfg;
    logic [GAIN_W-1:0] gain_sel;
    logic [TADDR_W-1:0] target_addr;
    logic [LOCK_W-1:0] lock_bits;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    dmm_core #(.NV_PROG_CYCLES(NPC)) dmm_core_inst (.core_clk(core_clk), .reset_n(reset_n),
        .nv_factory_init(nv_factory_init), .high_voltage_cmd_pin(high_voltage_cmd_pin), .bus_start(bus_start),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
        .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata), .ready(ready), .nv_prog_busy(nv_prog_busy),
        .chan0_code(chan0_code), .chan1_code(chan1_code), .vref_sel(vref_sel), .pd_cfg(pd_cfg),
        .gain_sel(gain_sel), .target_addr(target_addr), .lock_bits(lock_bits));
    dmm_cmd_master dmm_cmd_master_inst (.core_clk(core_clk), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack),
        .cmd_rdata(cmd_rdata), .bus_start(bus_start), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
    always #10 core_clk = ~core_clk;
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Ceiling is several times the expected run, so only a hang reaches it
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input dmm_cmd_t k, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic st);
        dmm_cmd_master_inst.issue(k, a, d, st, 0, ak, nk, rd);
    endtask
    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        cmd(CMD_READ, a, 16'h0000, 1'b1);
        chk({15'h0000, ak}, 16'h0001);
        chk(rd, e);
    endtask
    // Looks just after the edge so the busy flag seen is the settled one
    task automatic wait_idle();
        for (int i = 0; i < 20 && nv_prog_busy; i++)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task automatic t_defaults();
        chk({9'h000, target_addr}, 16'h0060);
        chk({11'h000, lock_bits}, 16'h0010);
        rd_chk(A_CH0, 16'h07FF);
        rd_chk(A_GS, 16'h0080);
        rd_chk(A_LOCK, 16'h0000);
        rd_chk(A_NV_GS, 16'h00E0);
    endtask
    task automatic t_map();
        logic [AW-1:0] a [7] = '{A_CH0, A_CH1, A_VREF, A_PD, A_GS, A_LOCK, A_GS};
        logic [DW-1:0] w [7] = '{16'hFFFF, 16'h1234, 16'hFFFF, 16'hFFF5, 16'hFFFF, 16'h5555, 16'h0100};
        logic [DW-1:0] e [7] = '{16'h0FFF, 16'h0234, 16'h000F, 16'h0005, 16'h0380, 16'h0000, 16'h0100};
        for (int i = 0; i < 7; i++)
        begin
            cmd(CMD_WRITE, a[i], w[i], 1'b0);
            chk({15'h0000, ak}, 16'h0001);
            rd_chk(a[i], e[i]);
        end
        chk(chan1_code, 16'h0234);
        chk({12'h000, vref_sel}, 16'h000F);
        chk({10'h000, gain_sel, pd_cfg}, 16'h0015);
    endtask
    task automatic t_reserved();
        for (int a = 0; a < 32; a++)
        begin
            if (!(a inside {0, 1, 8, 9, 10, 11, 16, 17, 24, 25, 26}))
            begin
                cmd(CMD_READ, 5'(a), 16'h0000, 1'b1);
                chk({15'h0000, nk}, 16'h0001);
                chk({15'h0000, ready}, 16'h0000);
                chk(rd, 16'hFFFF);
                cmd(CMD_WRITE, 5'(a), 16'h0000, 1'b1);
                chk({15'h0000, nk}, 16'h0001);
            end
        end
        cmd(CMD_READ, A_CH0, 16'h0000, 1'b0);
        chk({15'h0000, nk}, 16'h0001);
        rd_chk(A_CH0, 16'h0FFF);
    endtask
    task automatic t_hv();
        logic [AW-1:0] la [4] = '{A_CH0, A_NV_CH0, A_CH1, A_NV_CH1};
        cmd(CMD_HV_EN, A_CH0, 16'h0000, 1'b1);
        chk({15'h0000, nk}, 16'h0001);
        high_voltage_cmd_pin = 1'b1;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 4; i++)
        begin
            cmd(CMD_HV_EN, la[i], 16'h0000, 1'b1);
            chk({11'h000, lock_bits}, 16'h0010 | ((16'h0002 << i) - 16'h0001));
        end
        rd_chk(A_LOCK, 16'h000F);
        // Address lock is still set, so only bits 9:7 of 1Ah may change
        cmd(CMD_WRITE, A_NV_GS, 16'h027F, 1'b0);
        chk({15'h0000, ak}, 16'h0001);
        wait_idle();
        chk({9'h000, target_addr}, 16'h0060);
        rd_chk(A_NV_GS, 16'h0260);
        cmd(CMD_HV_EN, A_VREF, 16'h0000, 1'b1);
        chk({15'h0000, nk}, 16'h0001);
        cmd(CMD_HV_DIS, A_NV_GS, 16'h0000, 1'b1);
        chk({11'h000, lock_bits}, 16'h000F);
        high_voltage_cmd_pin = 1'b0;
    endtask
    task automatic t_nv();
        cmd(CMD_WRITE, A_NV_CH0, 16'h0ABC, 1'b0);
        chk({15'h0000, nv_prog_busy}, 16'h0001);
        cmd(CMD_WRITE, A_NV_CH1, 16'h0123, 1'b0);
        chk({15'h0000, nk}, 16'h0001);
        wait_idle();
        rd_chk(A_NV_CH0, 16'h0ABC);
        chk(chan0_code, 16'h0FFF);
        @(posedge core_clk);
        #1;
        reset_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        @(posedge core_clk);
        #1;
        chk(chan0_code, 16'h0ABC);
        chk({6'h00, vref_sel, gain_sel, pd_cfg}, 16'h0020);
        chk({11'h000, lock_bits}, 16'h000F);
        rd_chk(A_GS, 16'h0280);
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        nv_factory_init = 1'b0;
        t_defaults();
        t_map();
        t_reserved();
        t_hv();
        t_nv();
        test_done();
    end
endmodule
